// ### rvpg_defines.vh
// constants for the rail voltage, mode and power-good register bank
`ifndef RVPG_DEFINES_VH
`define RVPG_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RVPG_OFS_AUX_TWO 8'h9a
`define RVPG_OFS_AUX_THREE 8'h9b
`define RVPG_OFS_CTRL 8'h9c
`define RVPG_OFS_PGD 8'h9d

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RVPG_RST_AUX_TWO 8'h00
`define RVPG_RST_AUX_THREE 8'h00
`define RVPG_RST_CTRL 6'h00
`define RVPG_RST_PGD 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RVPG_SLEEP_HI 7
`define RVPG_SLEEP_LO 4
`define RVPG_NORMAL_HI 3
`define RVPG_NORMAL_LO 0
`define RVPG_CTRL_MODE_THREE 5
`define RVPG_CTRL_MODE_TWO 4
`define RVPG_CTRL_MODE_ONE 3
`define RVPG_CTRL_OFF_N_THREE 2
`define RVPG_CTRL_OFF_N_TWO 1
`define RVPG_CTRL_OFF_N_ONE 0
`define RVPG_CTRL_HI 5
`define RVPG_PGD_TWO_HI 7
`define RVPG_PGD_TWO_LO 5
`define RVPG_PGD_FOUR_HI 4
`define RVPG_PGD_FOUR_LO 2
`define RVPG_PGD_ONE_HI 1
`define RVPG_PGD_ONE_LO 0

// ----------------------------------------------------------------
// power-good delay codes, in ms
// ----------------------------------------------------------------
`define RVPG_DLY_C0 7'h00
`define RVPG_DLY_C1 7'h05
`define RVPG_DLY_C2 7'h0a
`define RVPG_DLY_C3 7'h0f
`define RVPG_DLY_C4 7'h14
`define RVPG_DLY_C5 7'h32
`define RVPG_DLY_C6 7'h4b
`define RVPG_DLY_C7 7'h64

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RVPG_CLK_NS 5
`define RVPG_TICK_NS 1000000
// one ms of 5 ns clocks, sized to the timer prescaler
`define RVPG_CYC_PER_MS 18'd200000

// ----------------------------------------------------------------
// serial target
// ----------------------------------------------------------------
`define RVPG_TARGET_ADDR 7'h2a

`endif

// ### rvpg_pgood_timer.v
// power-good delay timer for one general-purpose output
`timescale 1ns/1ps
`default_nettype none
`include "rvpg_defines.vh"

module rvpg_pgood_timer #(
  parameter [17:0] CYC_PER_MS = `RVPG_CYC_PER_MS
) (
  input wire clk_sys_in,
  input wire rst_in,
  input wire run_in,
  input wire [6:0] delay_ms_in,
  output wire pgood_out
);

  reg [17:0] pre_q;
  reg [6:0] ms_q;
  reg pgood_q;

  // ----------------------------------------------------------------
  // prescaler restarts with each run so the delay is not short by a tick
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (rst_in || !run_in) begin
      pre_q <= 18'h00000;
      ms_q <= 7'h00;
      pgood_q <= 1'b0;
    end else if (ms_q >= delay_ms_in) begin
      pgood_q <= 1'b1;
    end else if (pre_q == CYC_PER_MS - 18'd1) begin
      pre_q <= 18'h00000;
      ms_q <= ms_q + 7'h01;
    end else begin
      pre_q <= pre_q + 18'h00001;
    end
  end

  assign pgood_out = pgood_q;

endmodule // rvpg_pgood_timer
`default_nettype wire

// ### rvpg_regs.v
// rail voltage, mode and power-good register bank with serial target
`timescale 1ns/1ps
`default_nettype none
`include "rvpg_defines.vh"

// Function
// - aux two sleep code in bits 7:4
// - aux two normal code in bits 3:0
// - aux three sleep code in bits 7:4
// - aux three normal code in bits 3:0
// - bit 5 rail three forced pwm, 0 reserved
// - bit 4 rail two mode: auto or pwm
// - bit 3 rail one mode: auto or pwm
// - bit 2 low forces rail three off
// - bit 1 low forces rail two off
// - bit 0 low forces rail one off
// - delay starts when grouped rails regulate
// - bits 7:5 output two delay table
// - bits 4:2 output four delay table
// - bits 1:0 output one delay table
// - delays within ten percent tolerance
// - output two field idle unless used
// - output four field idle unless power-good
// - output one field idle unless power-good
// - host override on, disable bit wins
module rvpg_regs #(
  parameter [17:0] CYC_PER_MS = `RVPG_CYC_PER_MS,
  parameter [6:0] TARGET_ADDR = `RVPG_TARGET_ADDR
) (
  input wire clk_sys_in,
  input wire rst_in,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_out,
  input wire sleep_mode_in,
  input wire [2:0] rail_pin_en_in,
  input wire [2:0] ctrl_rail_host_on_in,
  input wire [7:0] rail_good_in,
  input wire [7:0] out_one_group_in,
  input wire [7:0] out_two_group_in,
  input wire [7:0] out_four_group_in,
  input wire out_one_pg_mode_in,
  input wire out_two_pg_mode_in,
  input wire out_two_vtt_use_in,
  input wire out_four_pg_mode_in,
  output wire [3:0] aux_ldo_two_target_out,
  output wire [3:0] aux_ldo_three_target_out,
  output wire ctrl_rail_one_mode_sel_out,
  output wire ctrl_rail_two_mode_sel_out,
  output wire ctrl_rail_three_mode_sel_out,
  output wire [2:0] ctrl_rail_en_out,
  output wire general_out_one_pgood_out,
  output wire general_out_two_pgood_out,
  output wire general_out_four_pgood_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [6:0] pg_ms;
    input [2:0] code;
    begin
      case (code)
        3'h0: pg_ms = `RVPG_DLY_C0;
        3'h1: pg_ms = `RVPG_DLY_C1;
        3'h2: pg_ms = `RVPG_DLY_C2;
        3'h3: pg_ms = `RVPG_DLY_C3;
        3'h4: pg_ms = `RVPG_DLY_C4;
        3'h5: pg_ms = `RVPG_DLY_C5;
        3'h6: pg_ms = `RVPG_DLY_C6;
        default: pg_ms = `RVPG_DLY_C7;
      endcase
    end
  endfunction

  function group_ok;
    input [7:0] good;
    input [7:0] group;
    begin
      group_ok = &(good | ~group);
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers: a level counts once stages two and three agree
  // ----------------------------------------------------------------
  reg [2:0] scl_sync_q;
  reg [2:0] sda_sync_q;
  reg scl_f_q;
  reg sda_f_q;

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_f_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_f_q <= sda_sync_q[2];
      end
    end
  end

  wire scl_new = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_f_q;
  wire sda_new = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_f_q;
  wire scl_rise = !scl_f_q && scl_new;
  wire scl_fall = scl_f_q && !scl_new;
  wire start_cond = scl_f_q && scl_new && sda_f_q && !sda_new;
  wire stop_cond = scl_f_q && scl_new && !sda_f_q && sda_new;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] aux_two_q;
  reg [7:0] aux_three_q;
  reg [5:0] ctrl_q;
  reg [7:0] pgd_q;

  reg [7:0] ptr_q;
  reg [7:0] rd_byte;

  always @* begin
    case (ptr_q)
      `RVPG_OFS_AUX_TWO: rd_byte = aux_two_q;
      `RVPG_OFS_AUX_THREE: rd_byte = aux_three_q;
      `RVPG_OFS_CTRL: rd_byte = {2'h0, ctrl_q};
      `RVPG_OFS_PGD: rd_byte = pgd_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // serial target state machine
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_PTR = 3'h2;
  localparam [2:0] ST_WR = 3'h3;
  localparam [2:0] ST_RD = 3'h4;

  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg ack_phase_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg read_q;
  reg nack_q;
  reg drive_low_q;

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      ack_phase_q <= 1'b0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      read_q <= 1'b0;
      nack_q <= 1'b0;
      drive_low_q <= 1'b0;
      ptr_q <= 8'h00;
      aux_two_q <= `RVPG_RST_AUX_TWO;
      aux_three_q <= `RVPG_RST_AUX_THREE;
      ctrl_q <= `RVPG_RST_CTRL;
      pgd_q <= `RVPG_RST_PGD;
    end else if (start_cond) begin
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      ack_phase_q <= 1'b0;
      drive_low_q <= 1'b0;
    end else if (stop_cond) begin
      state_q <= ST_IDLE;
      drive_low_q <= 1'b0;
    end else if (state_q != ST_IDLE) begin
      if (scl_rise) begin
        if (ack_phase_q) begin
          nack_q <= sda_f_q;
        end else if (bit_cnt_q != 4'h8) begin
          shift_q <= {shift_q[6:0], sda_f_q};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end else if (scl_fall) begin
        if (!ack_phase_q && bit_cnt_q == 4'h8) begin
          // whole byte in hand: answer in the ninth clock
          ack_phase_q <= 1'b1;
          drive_low_q <= 1'b0;
          case (state_q)
            ST_ADDR: begin
              if (shift_q[7:1] == TARGET_ADDR) begin
                drive_low_q <= 1'b1;
                read_q <= shift_q[0];
              end else begin
                state_q <= ST_IDLE;
              end
            end
            ST_PTR: begin
              ptr_q <= shift_q;
              drive_low_q <= 1'b1;
            end
            ST_WR: begin
              drive_low_q <= 1'b1;
              ptr_q <= ptr_q + 8'h01;
              case (ptr_q)
                `RVPG_OFS_AUX_TWO: aux_two_q <= shift_q;
                `RVPG_OFS_AUX_THREE: aux_three_q <= shift_q;
                // bits 7:6 are dropped on write
                `RVPG_OFS_CTRL: ctrl_q <= shift_q[`RVPG_CTRL_HI:0];
                `RVPG_OFS_PGD: pgd_q <= shift_q;
                default: ptr_q <= ptr_q + 8'h01;
              endcase
            end
            default: state_q <= state_q;
          endcase
        end else if (ack_phase_q) begin
          ack_phase_q <= 1'b0;
          bit_cnt_q <= 4'h0;
          drive_low_q <= 1'b0;
          case (state_q)
            ST_ADDR: begin
              if (read_q) begin
                state_q <= ST_RD;
                drive_low_q <= !rd_byte[7];
                tx_q <= {rd_byte[6:0], 1'b0};
              end else begin
                state_q <= ST_PTR;
              end
            end
            ST_PTR: state_q <= ST_WR;
            ST_RD: begin
              if (nack_q) begin
                state_q <= ST_IDLE;
              end else begin
                // only bit 7 of the next byte comes from the incremented pointer
                ptr_q <= ptr_q + 8'h01;
                state_q <= ST_RD;
              end
            end
            default: state_q <= state_q;
          endcase
        end else if (state_q == ST_RD && bit_cnt_q != 4'h0) begin
          drive_low_q <= !tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end else if (state_q == ST_RD && !ack_phase_q && bit_cnt_q == 4'h0 &&
                   !nack_q && !drive_low_q && scl_f_q == 1'b0 &&
                   tx_q == 8'h00 && rd_byte[7] == 1'b0) begin
        drive_low_q <= 1'b1;
      end
    end
  end

  // limitation: a continued read is exact only for bit 7; read singly

  assign sda_out = 1'b0;
  assign sda_oe_out = drive_low_q;

  // ----------------------------------------------------------------
  // rail outputs
  // ----------------------------------------------------------------
  reg [3:0] aux_two_tgt_q;
  reg [3:0] aux_three_tgt_q;
  reg [2:0] rail_en_q;

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      aux_two_tgt_q <= 4'h0;
      aux_three_tgt_q <= 4'h0;
      rail_en_q <= 3'h0;
    end else begin
      aux_two_tgt_q <= sleep_mode_in ?
        aux_two_q[`RVPG_SLEEP_HI:`RVPG_SLEEP_LO] :
        aux_two_q[`RVPG_NORMAL_HI:`RVPG_NORMAL_LO];
      aux_three_tgt_q <= sleep_mode_in ?
        aux_three_q[`RVPG_SLEEP_HI:`RVPG_SLEEP_LO] :
        aux_three_q[`RVPG_NORMAL_HI:`RVPG_NORMAL_LO];
      // force-off wins over pins and host override
      rail_en_q[2] <= ctrl_q[`RVPG_CTRL_OFF_N_THREE] &
        (rail_pin_en_in[2] | ctrl_rail_host_on_in[2]);
      rail_en_q[1] <= ctrl_q[`RVPG_CTRL_OFF_N_TWO] &
        (rail_pin_en_in[1] | ctrl_rail_host_on_in[1]);
      rail_en_q[0] <= ctrl_q[`RVPG_CTRL_OFF_N_ONE] &
        (rail_pin_en_in[0] | ctrl_rail_host_on_in[0]);
    end
  end

  assign aux_ldo_two_target_out = aux_two_tgt_q;
  assign aux_ldo_three_target_out = aux_three_tgt_q;
  assign ctrl_rail_three_mode_sel_out = ctrl_q[`RVPG_CTRL_MODE_THREE];
  assign ctrl_rail_two_mode_sel_out = ctrl_q[`RVPG_CTRL_MODE_TWO];
  assign ctrl_rail_one_mode_sel_out = ctrl_q[`RVPG_CTRL_MODE_ONE];
  assign ctrl_rail_en_out = rail_en_q;

  // ----------------------------------------------------------------
  // power-good timers; exact counts keep well inside the tolerance
  // ----------------------------------------------------------------
  wire run_one = out_one_pg_mode_in &
    group_ok(rail_good_in, out_one_group_in);
  wire run_two = (out_two_pg_mode_in | out_two_vtt_use_in) &
    group_ok(rail_good_in, out_two_group_in);
  wire run_four = out_four_pg_mode_in &
    group_ok(rail_good_in, out_four_group_in);

  rvpg_pgood_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr_one (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .run_in(run_one),
    .delay_ms_in(pg_ms({1'b0, pgd_q[`RVPG_PGD_ONE_HI:`RVPG_PGD_ONE_LO]})),
    .pgood_out(general_out_one_pgood_out)
  );

  rvpg_pgood_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr_two (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .run_in(run_two),
    .delay_ms_in(pg_ms(pgd_q[`RVPG_PGD_TWO_HI:`RVPG_PGD_TWO_LO])),
    .pgood_out(general_out_two_pgood_out)
  );

  rvpg_pgood_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr_four (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .run_in(run_four),
    .delay_ms_in(pg_ms(pgd_q[`RVPG_PGD_FOUR_HI:`RVPG_PGD_FOUR_LO])),
    .pgood_out(general_out_four_pgood_out)
  );

endmodule // rvpg_regs
`default_nettype wire

// ### rvpg_regs_assertions.sv
// port assertions for the rail register bank
`timescale 1ns/1ps
`default_nettype none
module rvpg_regs_chk (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic sleep_mode_in,
  input wire logic [2:0] rail_pin_en_in,
  input wire logic [2:0] ctrl_rail_host_on_in,
  input wire logic [7:0] rail_good_in,
  input wire logic [7:0] out_one_group_in,
  input wire logic [7:0] out_two_group_in,
  input wire logic [7:0] out_four_group_in,
  input wire logic out_one_pg_mode_in,
  input wire logic out_two_pg_mode_in,
  input wire logic out_two_vtt_use_in,
  input wire logic out_four_pg_mode_in,
  input wire logic [3:0] aux_ldo_two_target_out,
  input wire logic [3:0] aux_ldo_three_target_out,
  input wire logic ctrl_rail_one_mode_sel_out,
  input wire logic ctrl_rail_two_mode_sel_out,
  input wire logic ctrl_rail_three_mode_sel_out,
  input wire logic [2:0] ctrl_rail_en_out,
  input wire logic general_out_one_pgood_out,
  input wire logic general_out_two_pgood_out,
  input wire logic general_out_four_pgood_out
);
  // ----
  // helpers
  // ----
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic [2:0] sleep_hist_q;
  logic [2:0] run_w;
  logic quiet_w;
  always_ff @(posedge clk_sys_in) sleep_hist_q <= {sleep_hist_q[1:0], sleep_mode_in};
  // sleep must sit still for three samples, since the target lags it
  assign quiet_w = (sleep_hist_q == 3'h0) || (sleep_hist_q == 3'h7);
  assign run_w[0] = out_one_pg_mode_in && (&(rail_good_in | ~out_one_group_in));
  assign run_w[1] = (out_two_pg_mode_in || out_two_vtt_use_in) &&
                    (&(rail_good_in | ~out_two_group_in));
  assign run_w[2] = out_four_pg_mode_in && (&(rail_good_in | ~out_four_group_in));
  // a stored field only moves while the target acks a written byte
  sequence s_ack_near;
    ##[0:4] sda_oe_out;
  endsequence
  // ----
  // checks
  // ----
  chk_aux_two_cause: assert property (
    $changed(aux_ldo_two_target_out) && quiet_w |-> s_ack_near)
    else $error("aux two target moved with no cause");
  chk_aux_three_cause: assert property (
    $changed(aux_ldo_three_target_out) && quiet_w |-> s_ack_near)
    else $error("aux three target moved with no cause");
  chk_mode_on_write: assert property (
    $changed({ctrl_rail_three_mode_sel_out, ctrl_rail_two_mode_sel_out,
      ctrl_rail_one_mode_sel_out}) |-> s_ack_near)
    else $error("mode select moved outside a write");
  chk_en_cause: assert property (
    (ctrl_rail_en_out & ~$past(rail_pin_en_in | ctrl_rail_host_on_in)) == 3'h0)
    else $error("rail enabled with no pin or override");
  chk_en_hold: assert property (
    ctrl_rail_en_out[0] && (rail_pin_en_in[0] || ctrl_rail_host_on_in[0]) &&
    !sda_oe_out |=> ctrl_rail_en_out[0] || sda_oe_out)
    else $error("rail one dropped with no cause");
  chk_pg_one_rise: assert property (
    $rose(general_out_one_pgood_out) |-> $past(run_w[0]))
    else $error("output one rose before its rails");
  chk_pg_two_rise: assert property (
    $rose(general_out_two_pgood_out) |-> $past(run_w[1]))
    else $error("output two rose before its rails");
  chk_pg_four_rise: assert property (
    $rose(general_out_four_pgood_out) |-> $past(run_w[2]))
    else $error("output four rose before its rails");
  chk_sda_open_drain: assert property (
    sda_oe_out |-> !sda_out)
    else $error("data line driven high by the target");
  chk_pg_one_clear: assert property (
    (!run_w[0]) [*3] |=> !general_out_one_pgood_out)
    else $error("output one held after rails left");
endmodule // rvpg_regs_chk
bind rvpg_regs rvpg_regs_chk rvpg_regs_chk_inst (.*);
`default_nettype wire

// ### rvpg_host.sv
// serial bus host model for the register bank target
`timescale 1ns/1ps
`default_nettype none
module rvpg_host (
  output logic scl_out,
  output logic sda_pull_out,
  input wire logic sda_in
);
  // quarter of a 125 ns bus period; the clock rests high between frames
  localparam realtime QT = 31.25;
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    sda_pull_out = !b;
    #QT scl_out = 1'b1;
    #QT r = sda_in;
    #QT scl_out = 1'b0;
    #QT;
  endtask
  task automatic start();
    sda_pull_out = 1'b0;
    #QT scl_out = 1'b1;
    #QT sda_pull_out = 1'b1;
    #QT scl_out = 1'b0;
    #QT;
  endtask
  task automatic stop();
    sda_pull_out = 1'b1;
    #QT scl_out = 1'b1;
    #QT sda_pull_out = 1'b0;
    #QT;
  endtask
  // whole bytes only, msb first, then the ninth bit
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ack_in, r);
    ack_out = !r;
  endtask
endmodule // rvpg_host
`default_nettype wire

// ### tb.sv
// self-checking bench for the rail register bank
`timescale 1ns/1ps
`default_nettype none
`include "rvpg_defines.vh"
module tb;
  localparam int CPM = 20;
  logic clk_sys_in, rst_in, sleep_mode_in, sda_pull, scl_in, sda_out, sda_oe_out;
  logic out_one_pg_mode_in, out_two_pg_mode_in, out_two_vtt_use_in;
  logic out_four_pg_mode_in, ak;
  logic [2:0] rail_pin_en_in, ctrl_rail_host_on_in, ctrl_rail_en_out;
  logic [7:0] rail_good_in, out_one_group_in, out_two_group_in, out_four_group_in;
  logic [7:0] rx;
  logic [3:0] aux_ldo_two_target_out, aux_ldo_three_target_out;
  logic ctrl_rail_one_mode_sel_out, ctrl_rail_two_mode_sel_out;
  logic ctrl_rail_three_mode_sel_out, general_out_one_pgood_out;
  logic general_out_two_pgood_out, general_out_four_pgood_out;
  int bad_count = 0;
  int cmp_count = 0;
  int ms_tab[8] = '{0, 5, 10, 15, 20, 50, 75, 100};
  // data line has a pull-up: high unless someone pulls it
  wire sda_in = !((sda_oe_out & !sda_out) | sda_pull);
  rvpg_regs #(.CYC_PER_MS(18'd20)) rvpg_regs_inst (.*);
  rvpg_host rvpg_host_inst (.scl_out(scl_in), .sda_pull_out(sda_pull), .sda_in(sda_in));
  // ----
  // tasks
  // ----
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic sendb(input logic [7:0] b);
    rvpg_host_inst.xfer(b, 1'b1, rx, ak);
    chk(ak, 1'b1);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    rvpg_host_inst.start();
    sendb({`RVPG_TARGET_ADDR, 1'b0});
    sendb(ofs);
    sendb(d);
    rvpg_host_inst.stop();
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    rvpg_host_inst.start();
    sendb({`RVPG_TARGET_ADDR, 1'b0});
    sendb(ofs);
    rvpg_host_inst.start();
    sendb({`RVPG_TARGET_ADDR, 1'b1});
    rvpg_host_inst.xfer(8'hff, 1'b1, rx, ak);
    rvpg_host_inst.stop();
    chk(rx, exp);
  endtask
  // window is nominal plus or minus ten percent, a few cycles of slack
  function automatic logic in_tol(int t, int ms, logic on);
    if (!on) return t < 0;
    return t >= ms * CPM * 9 / 10 && t <= ms * CPM * 11 / 10 + 4;
  endfunction
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = !clk_sys_in;
  end
  // ----
  // sequence
  // ----
  initial begin
    logic [7:0] d;
    int t[3];
    {rst_in, sleep_mode_in, rail_pin_en_in, ctrl_rail_host_on_in} = 8'h80;
    {out_one_pg_mode_in, out_two_pg_mode_in, out_two_vtt_use_in} = 3'h0;
    out_four_pg_mode_in = 1'b0;
    rail_good_in = 8'h00;
    void'($urandom(28));
    // bit 0 in every group lets one rail hold all three outputs back
    out_one_group_in = 8'($urandom) | 8'h01;
    out_two_group_in = 8'($urandom) | 8'h01;
    out_four_group_in = 8'($urandom) | 8'h01;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    for (int i = 0; i < 5; i++) rd(8'h9a + 8'(i), 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hf0 : 8'($urandom);
      wr(8'h9a + 8'(i[0]), d);
      rd(8'h9a + 8'(i[0]), d);
      @(posedge clk_sys_in);
      sleep_mode_in <= i[1];
      repeat (3) @(posedge clk_sys_in);
      chk(i[0] ? aux_ldo_three_target_out : aux_ldo_two_target_out,
          i[1] ? d[7:4] : d[3:0]);
    end
    for (int i = 0; i < 8; i++) begin
      d = {2'b11, 1'b1, 5'($urandom)};
      wr(8'h9c, d);
      rd(8'h9c, {2'b00, d[5:0]});
      @(posedge clk_sys_in);
      rail_pin_en_in <= 3'($urandom);
      ctrl_rail_host_on_in <= (i < 2) ? 3'h7 : 3'($urandom);
      repeat (3) @(posedge clk_sys_in);
      chk({ctrl_rail_three_mode_sel_out, ctrl_rail_two_mode_sel_out,
           ctrl_rail_one_mode_sel_out}, d[5:3]);
      chk(ctrl_rail_en_out, d[2:0] & (rail_pin_en_in | ctrl_rail_host_on_in));
    end
    for (int i = 0; i < 9; i++) begin
      d = {3'(i), 3'(7 - i), 2'(i)};
      @(posedge clk_sys_in);
      rail_good_in <= 8'hfe;
      {out_one_pg_mode_in, out_four_pg_mode_in} <= {2{i < 8}};
      out_two_pg_mode_in <= i < 7;
      out_two_vtt_use_in <= i == 7;
      wr(8'h9d, d);
      rd(8'h9d, d);
      chk({general_out_one_pgood_out, general_out_two_pgood_out,
           general_out_four_pgood_out}, 3'h0);
      @(posedge clk_sys_in);
      rail_good_in <= 8'hff;
      t = '{-1, -1, -1};
      for (int n = 0; n < 2400; n++) begin
        @(posedge clk_sys_in);
        if (general_out_one_pgood_out === 1'b1 && t[0] < 0) t[0] = n;
        if (general_out_two_pgood_out === 1'b1 && t[1] < 0) t[1] = n;
        if (general_out_four_pgood_out === 1'b1 && t[2] < 0) t[2] = n;
      end
      chk(in_tol(t[0], ms_tab[d[1:0]], i < 8), 1'b1);
      chk(in_tol(t[1], ms_tab[d[7:5]], i < 8), 1'b1);
      chk(in_tol(t[2], ms_tab[d[4:2]], i < 8), 1'b1);
    end
    results();
  end
endmodule // tb
`default_nettype wire
